//--- src/msa_storage.sv
module msa_storage
	import msa_pkg::*;
(
	// Clock and reset
	input  wire logic                         clk,
	input  wire logic                         sys_rst,
	// Cabinet switches
	input  wire logic [NUM_CABS*CAB_SEL_W-1:0] cab_base_sw,
	input  wire logic [NUM_CABS-1:0]          cab_online,
	// Request
	input  wire logic                         req_valid,
	output logic                              req_ready,
	input  wire msa_req_type                  req,
	// Response
	output logic                              rsp_valid,
	output msa_rsp_type                       rsp
);
	// ==========================================
	// Cabinets
	// ==========================================
	msa_state_type state_ff, nxt_state;
	logic [CNT_W-1:0] cnt_ff, nxt_cnt;
	msa_req_type      req_ff, nxt_req;
	msa_rsp_type      rsp_ff, nxt_rsp;
	logic [NUM_CABS-1:0] hit;
	logic [31:0]         rd   [NUM_CABS];
	logic [LANES-1:0]    rp   [NUM_CABS];
	logic                wr_fire;
	logic                prot_bad;

	// Cabinets with no online bit stay silent; capacity set by cab_online
	for (genvar c = 0; c < NUM_CABS; c++) begin : g_cab
		msa_cabinet u_cab (
			.clk      (clk),
			.base_sw  (cab_base_sw[c*CAB_SEL_W +: CAB_SEL_W]),
			.online   (cab_online[c]),
			.addr     (req_ff.addr),
			.wr_en    (wr_fire),
			.byte_sel (req_ff.byte_sel),
			.wdata    (req_ff.wdata),
			.hit      (hit[c]),
			.rdata    (rd[c]),
			.rpar     (rp[c])
		);
	end

	// ==========================================
	// Select and check
	// ==========================================
	logic [31:0]      sel_data;
	logic [LANES-1:0] sel_par;
	logic             any_hit;
	logic             par_bad;

	// Lowest-numbered cabinet wins if two share a base
	always_comb begin
		sel_data = '0;
		sel_par  = '0;
		any_hit  = 1'b0;
		for (int c = NUM_CABS - 1; c >= 0; c--) begin
			if (hit[c]) begin
				sel_data = rd[c];
				sel_par  = rp[c];
				any_hit  = 1'b1;
			end
		end
		par_bad = 1'b0;
		for (int l = 0; l < LANES; l++) begin
			if (req_ff.byte_sel[l] && (^sel_data[31 - l*BYTE_W -: BYTE_W] != sel_par[l])) begin
				par_bad = 1'b1;
			end
		end
	end

	// Low storage open to supervisor, else only when permitted
	assign prot_bad = (req_ff.addr < LOW_RES_LIMIT) && !req_ff.supervisor
		&& !req_ff.low_allowed;

	// Write lands once, at the last tick of the cycle
	assign wr_fire = (state_ff == MSA_BUSY) && (cnt_ff == CYCLE_LAST) && req_ff.write
		&& any_hit && !prot_bad;

	// ==========================================
	// Word cycle sequencer
	// ==========================================
	assign req_ready = (state_ff == MSA_IDLE);
	assign rsp_valid = (state_ff == MSA_DONE);
	assign rsp       = rsp_ff;

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		nxt_req   = req_ff;
		nxt_rsp   = rsp_ff;
		case (state_ff)
			MSA_IDLE: begin
				if (req_valid) begin
					// Word address from any byte; low bits ignored, byte_sel picks lanes
					nxt_req   = req;
					nxt_cnt   = '0;
					nxt_state = MSA_BUSY;
				end
			end
			MSA_BUSY: begin
				// Same length for 1..4 bytes
				if (cnt_ff == CYCLE_LAST) begin
					nxt_rsp.rdata      = req_ff.write ? 32'h0 : sel_data;
					nxt_rsp.rparity    = req_ff.write ? 4'h0 : sel_par;
					nxt_rsp.parity_err = !req_ff.write && any_hit && !prot_bad && par_bad;
					nxt_rsp.addr_err   = !any_hit;
					nxt_rsp.prot_err   = any_hit && prot_bad;
					nxt_state          = MSA_DONE;
				end else begin
					nxt_cnt = cnt_ff + 7'h01;
				end
			end
			MSA_DONE: begin
				nxt_state = MSA_IDLE;
			end
			default: begin
				nxt_state = MSA_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_ff <= MSA_IDLE;
			cnt_ff   <= '0;
			req_ff   <= '0;
			rsp_ff   <= '0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
			req_ff   <= nxt_req;
			rsp_ff   <= nxt_rsp;
		end
	end
endmodule : msa_storage

//--- pkg/msa_pkg.sv
// What this block does
// - One word cycle takes fixed 600 ns
// - Byte addressable, each byte has parity
// - Byte addresses span zero to 1048575
// - Group addressed by leftmost byte, bit0 MSB
// - Installed storage from 131K to 1048K
// - Cabinet decodes only its 131072 bytes
// - Cabinet base from switches, multiple of 131072
// - Variable fields accepted at any byte
// - Low 640 bytes reserved, supervisor reaches them
// - Problem mode reaches low storage if permitted
// - Byte selects write; unselected bytes unchanged
package msa_pkg;
	localparam int ADDR_W         = 20;
	localparam int BYTE_W         = 8;
	localparam int LANES          = 4;
	localparam int CAB_ADDR_W     = 17;
	localparam int CAB_SEL_W      = ADDR_W - CAB_ADDR_W;
	localparam int NUM_CABS       = 8;
	localparam int WORD_IDX_W     = CAB_ADDR_W - 2;
	localparam int CAB_WORDS      = 32768;
	localparam int LOW_RES_BYTES  = 640;
	localparam int CYCLE_NS       = 600;
	localparam int CLK_NS         = 10;
	localparam int CYCLE_CLKS     = CYCLE_NS / CLK_NS;
	localparam int CNT_W          = 7;
	localparam logic [CNT_W-1:0] CYCLE_LAST = CNT_W'(CYCLE_CLKS - 1);
	localparam logic [ADDR_W-1:0] LOW_RES_LIMIT = ADDR_W'(LOW_RES_BYTES);

	typedef struct packed {
		logic              write;
		logic              supervisor;
		logic              low_allowed;
		logic [ADDR_W-1:0] addr;
		logic [LANES-1:0]  byte_sel;
		logic [31:0]       wdata;
	} msa_req_type;

	typedef struct packed {
		logic [31:0]      rdata;
		logic [LANES-1:0] rparity;
		logic             parity_err;
		logic             addr_err;
		logic             prot_err;
	} msa_rsp_type;

	typedef enum logic [1:0] {
		MSA_IDLE,
		MSA_BUSY,
		MSA_DONE
	} msa_state_type;
endpackage : msa_pkg

//--- src/msa_cabinet.sv
module msa_cabinet
	import msa_pkg::*;
(
	// Clock
	input  wire logic                    clk,
	// Base switch and enable
	input  wire logic [CAB_SEL_W-1:0]    base_sw,
	input  wire logic                    online,
	// Access
	input  wire logic [ADDR_W-1:0]       addr,
	input  wire logic                    wr_en,
	input  wire logic [LANES-1:0]        byte_sel,
	input  wire logic [31:0]             wdata,
	// Result
	output logic                         hit,
	output logic [31:0]                  rdata,
	output logic [LANES-1:0]             rpar
);
	logic [WORD_IDX_W-1:0] widx;

	// Cabinet answers only its base-aligned window
	assign hit  = online && (addr[ADDR_W-1:CAB_ADDR_W] == base_sw);
	assign widx = addr[CAB_ADDR_W-1:2];

	// Lane 0 holds the leftmost byte, the most significant one
	for (genvar l = 0; l < LANES; l++) begin : g_lane
		localparam int HI = 31 - l * BYTE_W;
		// One array per lane keeps a single writing process per array
		logic [BYTE_W:0] lane_mem [CAB_WORDS];
		always_ff @(posedge clk) begin
			if (wr_en && hit && byte_sel[l]) begin
				lane_mem[widx] <= {^wdata[HI -: BYTE_W], wdata[HI -: BYTE_W]};
			end
		end
		assign rdata[HI -: BYTE_W] = lane_mem[widx][BYTE_W-1:0];
		assign rpar[l]             = lane_mem[widx][BYTE_W];
	end
endmodule : msa_cabinet

//--- verif/msa_req_model.sv
// ==========
// Requester
module msa_req_model
	import msa_pkg::*;
(
	// Bus
	input  wire logic clk,
	input  wire logic req_ready,
	output logic      req_valid,
	output msa_req_type req
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		req_valid = 1'b0;
		req = '0;
	end
	// Holds the request until taken; caller aligns fields
	task automatic issue(input msa_req_type r);
		req_valid <= 1'b1;
		req <= r;
		@(posedge clk);
		while (!req_ready)
			@(posedge clk);
		req_valid <= 1'b0;
		req <= ~r;
	endtask : issue
endmodule : msa_req_model

//--- verif/msa_storage_monitor.sv
// ==========
// Checker
module msa_storage_monitor
	import msa_pkg::*;
(
	// Ports
	input wire logic                          clk,
	input wire logic                          sys_rst,
	input wire logic [NUM_CABS*CAB_SEL_W-1:0] cab_base_sw,
	input wire logic [NUM_CABS-1:0]           cab_online,
	input wire logic                          req_valid,
	input wire logic                          req_ready,
	input wire msa_req_type                   req,
	input wire logic                          rsp_valid,
	input wire msa_rsp_type                   rsp
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic take, miss, lowp;
	assign take = req_valid && req_ready;
	assign lowp = !req.supervisor && !req.low_allowed && req.addr < LOW_RES_LIMIT;
	always_comb begin
		miss = 1'b1;
		for (int c = 0; c < NUM_CABS; c++)
			if (cab_online[c] && cab_base_sw[c*CAB_SEL_W +: CAB_SEL_W] == req.addr[19:17])
				miss = 1'b0;
	end
	sequence taken_s;
		take;
	endsequence
	sequence answer_s;
		##61 rsp_valid;
	endsequence
	chk_cycle_len: assert property (taken_s |-> answer_s)
		else $error("late answer");
	chk_ready_low: assert property (taken_s |=> !req_ready [*8])
		else $error("ready early");
	chk_no_early: assert property (rsp_valid |-> $past(take, 61))
		else $error("early answer");
	chk_pulse_once: assert property (rsp_valid |=> !rsp_valid && req_ready)
		else $error("pulse length");
	chk_rsp_hold: assert property (!rsp_valid |-> $stable(rsp))
		else $error("rsp moved");
	chk_prot_low: assert property (taken_s ##0 (lowp && !miss) |-> ##61 rsp.prot_err)
		else $error("no prot_err");
	chk_super_ok: assert property (take && req.supervisor |-> ##61 !rsp.prot_err)
		else $error("prot_err set");
	chk_addr_miss: assert property (take && miss |-> ##61 rsp.addr_err)
		else $error("no addr_err");
endmodule : msa_storage_monitor
bind msa_storage msa_storage_monitor msa_storage_monitor_i (.clk, .sys_rst, .cab_base_sw,
	.cab_online, .req_valid, .req_ready, .req, .rsp_valid, .rsp);

//--- verif/msa_storage_bench.sv
// ==========
// Bench
module msa_storage_bench;
	import msa_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        req_valid, req_ready, rsp_valid;
	msa_req_type req;
	msa_rsp_type rsp;
	logic [31:0] mem [int];
	logic [19:0] a;
	int n_errors = 0, samples_checked = 0, seed = 32'hcd5bfc0d;
	always #5 clk = ~clk;
	// Cabinet 3 takes the base of offline cabinet 2
	msa_storage msa_storage_i (.clk, .sys_rst, .cab_base_sw(24'hfac488),
		.cab_online(8'h0b), .req_valid, .req_ready, .req, .rsp_valid, .rsp);
	msa_req_model msa_req_model_i (.clk, .req_ready, .req_valid, .req);
	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	function automatic logic [31:0] par4(logic [31:0] d);
		par4 = '0;
		for (int l = 0; l < 4; l++)
			par4[l] = ^d[31-8*l -: 8];
	endfunction : par4
	task automatic rst_chk;
		sys_rst <= 1'b1;
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		@(negedge clk);
		chk("req_ready", req_ready, 1);
		chk("rsp_valid", rsp_valid, 0);
		chk("rsp_rdata", rsp.rdata, 0);
	endtask : rst_chk
	task automatic final_report;
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : final_report
	task automatic op(logic w, s, la, logic [19:0] ad, logic [3:0] bs, logic [31:0] d);
		logic ae, pe;
		int k;
		ae = ad[19:17] > 3'h2;
		pe = !s && !la && ad < 20'd640;
		k = ad[19:2];
		@(posedge clk);
		msa_req_model_i.issue('{w, s, la, ad, bs, d});
		for (int t = 0; t < 100 && !rsp_valid; t++)
			@(negedge clk);
		chk("rsp_valid", rsp_valid, 1);
		chk("addr_err", rsp.addr_err, ae);
		chk("prot_err", rsp.prot_err, pe);
		if (!ae && !pe && w) begin
			for (int l = 0; l < 4; l++)
				if (bs[l])
					mem[k][31-8*l -: 8] = d[31-8*l -: 8];
			chk("wr_rdata", rsp.rdata, 0);
		end else if (!ae && !w) begin
			chk("rdata", rsp.rdata, mem[k]);
			chk("parity_err", rsp.parity_err, 0);
			chk("rparity", rsp.rparity, par4(mem[k]));
		end
	endtask : op
	initial begin
		rst_chk;
		op(1, 1, 0, 20'h10, 4'hf, 32'h11223344);
		op(1, 0, 0, 20'h10, 4'hf, 32'hffffffff);
		op(0, 0, 1, 20'h13, 4'h0, 0);
		op(0, 0, 0, 20'h10, 4'h0, 0);
		op(1, 1, 0, 20'h5fffc, 4'hf, 32'h89abcdef);
		op(0, 1, 0, 20'h5ffff, 4'h0, 0);
		op(1, 1, 1, 20'h60000, 4'hf, 0);
		op(0, 1, 1, 20'hfffff, 4'h0, 0);
		repeat (12) begin
			a = 20'({$random(seed)} % 393216);
			op(1, 1, 0, a, 4'hf, $random(seed));
			op(1, 1'($random(seed)), 1, a ^ 20'h3, 4'($random(seed)), $random(seed));
			op(0, 1, 0, a, 4'h0, 0);
		end
		// Reset mid-run: outputs clear, stored words survive
		rst_chk;
		op(0, 1, 0, a, 4'h0, 0);
		final_report;
	end
	initial begin
		#100000;
		n_errors++;
		final_report;
	end
endmodule : msa_storage_bench
